// file: ccs_defines.svh
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH

// status register bit positions
`define CCS_FLAG_I 7
`define CCS_FLAG_T 6
`define CCS_FLAG_H 5
`define CCS_FLAG_S 4
`define CCS_FLAG_V 3
`define CCS_FLAG_N 2
`define CCS_FLAG_Z 1
`define CCS_FLAG_C 0
`define CCS_STATUS_RESET 8'h00

// register file and data space
`define CCS_GPR_COUNT 32
`define CCS_GPR_RESET 8'h00
`define CCS_GPR_SPAN_LAST 16'h001F
`define CCS_PTR_X_LO 5'h1A
`define CCS_PTR_Y_LO 5'h1C
`define CCS_PTR_Z_LO 5'h1E

// stack pointer: 11 implemented bits
`define CCS_SP_BITS 11
`define CCS_TOP_OF_DATA_MEMORY 11'h04FF

// interrupts and program space
`define CCS_NUM_IRQ 25
`define CCS_IRQ_IDX_BITS 5
`define CCS_PC_BITS 13
`define CCS_BOOT_START 13'h1C00
`define CCS_VECTOR_ZERO 13'h0000
`define CCS_ENTRY_CYCLES 3'h4

`endif

// file: ccs_pkg.sv
package ccs_pkg;

  typedef enum logic [2:0] {
    CCS_ALU_ADD, CCS_ALU_ADC, CCS_ALU_SUB, CCS_ALU_SBC,
    CCS_ALU_AND, CCS_ALU_OR, CCS_ALU_EOR, CCS_ALU_MOV
  } ccs_alu_op_e;

  typedef enum logic [1:0] {CCS_PTR_X, CCS_PTR_Y, CCS_PTR_Z} ccs_ptr_e;

  typedef enum logic [1:0] {
    CCS_PM_PLAIN, CCS_PM_DISP, CCS_PM_POSTINC, CCS_PM_PREDEC
  } ccs_ptr_mode_e;

  typedef enum logic [1:0] {CCS_IO_STATUS, CCS_IO_SP_HIGH, CCS_IO_SP_LOW} ccs_io_e;

  typedef enum {CCS_ST_IDLE, CCS_ST_ENTRY} ccs_entry_e;

endpackage

// file: ccs_irq_pick.sv
`include "ccs_defines.svh"

module ccs_irq_pick
  import ccs_pkg::*;
(
  // requests and their own enables
  input wire logic [`CCS_NUM_IRQ-1:0] req_i,
  input wire logic [`CCS_NUM_IRQ-1:0] en_i,
  // winner
  output logic any_o,
  output logic [`CCS_IRQ_IDX_BITS-1:0] idx_o,
  output logic [`CCS_NUM_IRQ-1:0] grant_o
);

  logic [`CCS_NUM_IRQ-1:0] act;

  assign act = req_i & en_i;
  assign any_o = |act;

  // lowest index is the lowest vector, so it wins
  genvar g;
  generate
    for (g = 0; g < `CCS_NUM_IRQ; g = g + 1) begin : g_pick
      if (g == 0) begin : g_first
        assign grant_o[g] = act[g];
      end else begin : g_rest
        assign grant_o[g] = act[g] & ~(|act[g-1:0]);
      end
    end
  endgenerate

  always_comb begin
    idx_o = '0;
    for (int i = 0; i < `CCS_NUM_IRQ; i++) begin
      if (grant_o[i]) begin
        idx_o = idx_o | `CCS_IRQ_IDX_BITS'(i);
      end
    end
  end

endmodule // ccs_irq_pick

// file: ccs_core_state.sv
// Operation
// - sign flag is always negative xor overflow, bit 4
// - bit 3 holds two's complement overflow of signed arithmetic
// - bit 2 set on negative result, cleared otherwise
// - bit 1 set on zero result, cleared otherwise
// - bit 0 records carry of the operation
// - register file offers 8-bit and 16-bit read and write schemes per cycle
// - register n also answers at data address n, 0x00 to 0x1F
// - registers 26..31 form three pointers, low byte at even register
// - pointers support displacement, post-increment and pre-decrement
// - push decrements stack pointer by one, pop increments by one
// - call or entry subtract two; return or interrupt return add two
// - stack pointer is two readable, writable bytes reset to memory top
// - two-operand alu op reads, computes and writes back in one cycle
// - core runs on the undivided chip clock
// - source taken only if own enable and global enable are one
// - lowest vector first; reset highest, then external request zero
// - select bit moves vectors to boot start; fuse moves reset vector
// - boot lock settings suppress interrupts depending on program counter
// - taking an interrupt clears global enable; software may re-enable
// - interrupt return sets global enable again
// - global enable is bit 7; clear means nothing is taken
// - interrupt entry lasts at least four cycles before the vector
`include "ccs_defines.svh"

module ccs_core_state
  import ccs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register file operand ports
  input wire logic [4:0] rd_a_sel_i,
  input wire logic [4:0] rd_b_sel_i,
  output logic [7:0] rd_a_data_o,
  output logic [7:0] rd_b_data_o,
  output logic [15:0] rd_word_o,
  input wire logic wr_en_i,
  input wire logic wr_wide_i,
  input wire logic [4:0] wr_sel_i,
  input wire logic [15:0] wr_data_i,
  // alu
  input wire logic alu_en_i,
  input wire ccs_alu_op_e alu_op_i,
  input wire logic [4:0] alu_dst_i,
  input wire logic [4:0] alu_src_i,
  // data space window onto the register file
  input wire logic ds_en_i,
  input wire logic ds_we_i,
  input wire logic [15:0] ds_addr_i,
  input wire logic [7:0] ds_wdata_i,
  output logic ds_hit_o,
  output logic [7:0] ds_rdata_o,
  // pointer addressing
  input wire logic ptr_go_i,
  input wire ccs_ptr_e ptr_sel_i,
  input wire ccs_ptr_mode_e ptr_mode_i,
  input wire logic [5:0] ptr_disp_i,
  output logic [15:0] ptr_addr_o,
  // i/o register port
  input wire logic io_en_i,
  input wire logic io_we_i,
  input wire ccs_io_e io_sel_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  // instruction events
  input wire logic sei_i,
  input wire logic cli_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic call_i,
  input wire logic ret_i,
  input wire logic interrupt_return_instr_i,
  input wire logic instr_done_i,
  // interrupt sources and boot controls
  input wire logic [`CCS_NUM_IRQ-1:0] irq_req_i,
  input wire logic [`CCS_NUM_IRQ-1:0] irq_en_i,
  input wire logic vector_relocate_select_i,
  input wire logic boot_reset_vector_fuse_i,
  input wire logic app_lock_bit_two_i,
  input wire logic boot_lock_bit_two_i,
  input wire logic [`CCS_PC_BITS-1:0] pc_i,
  // interrupt entry
  output logic irq_take_o,
  output logic [`CCS_NUM_IRQ-1:0] irq_ack_o,
  output logic irq_busy_o,
  output logic vector_valid_o,
  output logic [`CCS_PC_BITS-1:0] vector_addr_o,
  output logic [`CCS_PC_BITS-1:0] reset_vector_o,
  // architectural state
  output logic [7:0] status_o,
  output logic [15:0] sp_o
);

  // clk_i is the core clock itself; nothing here divides it
  logic [7:0] gpr_q [`CCS_GPR_COUNT];
  logic [7:0] gpr_d [`CCS_GPR_COUNT];
  logic [7:0] flags_q, flags_d;
  logic [`CCS_SP_BITS-1:0] sp_q, sp_d;
  logic hold_q, vec_valid_q;
  logic [`CCS_PC_BITS-1:0] vec_q, rst_vec_q;
  logic [2:0] cnt_q;
  ccs_entry_e st_q;

  ////////////////////////////////////////////////////////////////////////////
  // read ports and data space window

  assign rd_a_data_o = gpr_q[rd_a_sel_i];
  assign rd_b_data_o = gpr_q[rd_b_sel_i];
  assign rd_word_o = {gpr_q[rd_a_sel_i | 5'h01], gpr_q[rd_a_sel_i & 5'h1E]};

  wire ds_in_span = ds_addr_i <= `CCS_GPR_SPAN_LAST;
  assign ds_hit_o = ds_en_i && ds_in_span;
  assign ds_rdata_o = ds_hit_o ? gpr_q[ds_addr_i[4:0]] : 8'h00;
  wire ds_wr = ds_hit_o && ds_we_i;

  ////////////////////////////////////////////////////////////////////////////
  // pointers

  wire [4:0] ptr_lo = (ptr_sel_i == CCS_PTR_X) ? `CCS_PTR_X_LO :
                      (ptr_sel_i == CCS_PTR_Y) ? `CCS_PTR_Y_LO : `CCS_PTR_Z_LO;
  wire [15:0] ptr_val = {gpr_q[ptr_lo | 5'h01], gpr_q[ptr_lo]};
  wire [15:0] ptr_inc = ptr_val + 16'h0001;
  wire [15:0] ptr_dec = ptr_val - 16'h0001;
  wire [15:0] ptr_disp = ptr_val + {10'h000, ptr_disp_i};
  wire ptr_upd = ptr_go_i && (ptr_mode_i == CCS_PM_POSTINC || ptr_mode_i == CCS_PM_PREDEC);
  wire [15:0] ptr_new = (ptr_mode_i == CCS_PM_POSTINC) ? ptr_inc : ptr_dec;
  assign ptr_addr_o = (ptr_mode_i == CCS_PM_PREDEC) ? ptr_dec :
                      (ptr_mode_i == CCS_PM_DISP) ? ptr_disp : ptr_val;

  ////////////////////////////////////////////////////////////////////////////
  // alu: operands straight from the file, result written at the same edge

  wire [7:0] opa = gpr_q[alu_dst_i];
  wire [7:0] opb = gpr_q[alu_src_i];
  wire use_cin = (alu_op_i == CCS_ALU_ADC || alu_op_i == CCS_ALU_SBC);
  wire cin = use_cin && flags_q[`CCS_FLAG_C];
  wire [8:0] sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
  wire [8:0] dif9 = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
  logic [7:0] alu_res;
  logic alu_c, alu_v, alu_h, alu_flags;

  always_comb begin
    alu_res = opb;
    alu_c = flags_q[`CCS_FLAG_C];
    alu_v = 1'b0;
    alu_h = flags_q[`CCS_FLAG_H];
    alu_flags = 1'b1;
    case (alu_op_i)
      CCS_ALU_ADD, CCS_ALU_ADC: begin
        {alu_c, alu_res} = sum9;
        alu_v = (opa[7] & opb[7] & ~sum9[7]) | (~opa[7] & ~opb[7] & sum9[7]);
        alu_h = (opa[3] & opb[3]) | (opb[3] & ~sum9[3]) | (~sum9[3] & opa[3]);
      end
      CCS_ALU_SUB, CCS_ALU_SBC: begin
        {alu_c, alu_res} = dif9;
        alu_v = (opa[7] & ~opb[7] & ~dif9[7]) | (~opa[7] & opb[7] & dif9[7]);
        alu_h = (~opa[3] & opb[3]) | (opb[3] & dif9[3]) | (dif9[3] & ~opa[3]);
      end
      CCS_ALU_AND: alu_res = opa & opb;
      CCS_ALU_OR: alu_res = opa | opb;
      CCS_ALU_EOR: alu_res = opa ^ opb;
      CCS_ALU_MOV: alu_flags = 1'b0;
      default: alu_flags = 1'b0;
    endcase
  end

  wire alu_zero = alu_res == 8'h00;
  wire alu_flag_wr = alu_en_i && alu_flags;

  ////////////////////////////////////////////////////////////////////////////
  // register file write, one next-state per register

  genvar g;
  generate
    for (g = 0; g < `CCS_GPR_COUNT; g = g + 1) begin : g_gpr
      localparam logic [4:0] IDX = 5'(g);
      wire hit_alu = alu_en_i && alu_dst_i == IDX;
      wire hit_wide = wr_en_i && wr_wide_i && wr_sel_i[4:1] == IDX[4:1];
      wire hit_byte = wr_en_i && !wr_wide_i && wr_sel_i == IDX;
      wire hit_ptr = ptr_upd && ptr_lo[4:1] == IDX[4:1];
      wire hit_ds = ds_wr && ds_addr_i[4:0] == IDX;
      always_comb begin
        if (hit_alu) begin
          gpr_d[g] = alu_res;
        end else if (hit_wide) begin
          gpr_d[g] = IDX[0] ? wr_data_i[15:8] : wr_data_i[7:0];
        end else if (hit_byte) begin
          gpr_d[g] = wr_data_i[7:0];
        end else if (hit_ptr) begin
          gpr_d[g] = IDX[0] ? ptr_new[15:8] : ptr_new[7:0];
        end else if (hit_ds) begin
          gpr_d[g] = ds_wdata_i;
        end else begin
          gpr_d[g] = gpr_q[g];
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) gpr_q[g] <= `CCS_GPR_RESET;
        else gpr_q[g] <= gpr_d[g];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // interrupt selection

  logic pick_any;
  logic [`CCS_IRQ_IDX_BITS-1:0] pick_idx;
  logic [`CCS_NUM_IRQ-1:0] pick_grant;

  ccs_irq_pick u_pick (
    .req_i(irq_req_i),
    .en_i(irq_en_i),
    .any_o(pick_any),
    .idx_o(pick_idx),
    .grant_o(pick_grant)
  );

  wire in_boot = pc_i >= `CCS_BOOT_START;
  // locked section may not be left through a vector in the other one
  wire suppress = (app_lock_bit_two_i && vector_relocate_select_i && !in_boot) ||
                  (boot_lock_bit_two_i && !vector_relocate_select_i && in_boot);
  // cli acts at once, so a request in the same cycle is refused
  assign irq_take_o = st_q == CCS_ST_IDLE && !vec_valid_q && instr_done_i && !hold_q &&
                      flags_q[`CCS_FLAG_I] && !cli_i && pick_any && !suppress;
  assign irq_ack_o = irq_take_o ? pick_grant : '0;

  wire [`CCS_PC_BITS-1:0] vec_base = vector_relocate_select_i ? `CCS_BOOT_START :
                                     `CCS_VECTOR_ZERO;
  // vector 0 is reset, request k sits two words per slot above it
  wire [`CCS_PC_BITS-1:0] vec_num = {8'h00, pick_idx} + 13'h0001;
  wire [`CCS_PC_BITS-1:0] vec_calc = vec_base + {vec_num[11:0], 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // status register

  wire io_wr = io_en_i && io_we_i;
  wire st_wr = io_wr && io_sel_i == CCS_IO_STATUS;

  always_comb begin
    flags_d = st_wr ? io_wdata_i : flags_q;
    if (alu_flag_wr) begin
      flags_d[`CCS_FLAG_N] = alu_res[7];
      flags_d[`CCS_FLAG_Z] = alu_zero;
      flags_d[`CCS_FLAG_C] = alu_c;
      flags_d[`CCS_FLAG_V] = alu_v;
      flags_d[`CCS_FLAG_H] = alu_h;
    end
    if (cli_i) flags_d[`CCS_FLAG_I] = 1'b0;
    if (sei_i) flags_d[`CCS_FLAG_I] = 1'b1;
    if (irq_take_o) flags_d[`CCS_FLAG_I] = 1'b0;
    if (interrupt_return_instr_i) flags_d[`CCS_FLAG_I] = 1'b1;
    // sign is never stored, it is derived on read
    flags_d[`CCS_FLAG_S] = 1'b0;
  end

  wire s_flag = flags_q[`CCS_FLAG_N] ^ flags_q[`CCS_FLAG_V];
  assign status_o = {flags_q[7:5], s_flag, flags_q[3:0]};

  // one more instruction runs after global enable rises, before any entry
  wire ien_rise = interrupt_return_instr_i || ((sei_i || (st_wr && io_wdata_i[`CCS_FLAG_I])) &&
                  !flags_q[`CCS_FLAG_I]);

  ////////////////////////////////////////////////////////////////////////////
  // stack pointer

  wire sph_wr = io_wr && io_sel_i == CCS_IO_SP_HIGH;
  wire spl_wr = io_wr && io_sel_i == CCS_IO_SP_LOW;
  wire [15:0] sp_full = {{(16 - `CCS_SP_BITS){1'b0}}, sp_q};

  always_comb begin
    if (sph_wr) begin
      sp_d = {io_wdata_i[`CCS_SP_BITS-9:0], sp_q[7:0]};
    end else if (spl_wr) begin
      sp_d = {sp_q[`CCS_SP_BITS-1:8], io_wdata_i};
    end else if (irq_take_o || call_i) begin
      sp_d = sp_q - `CCS_SP_BITS'(2);
    end else if (ret_i || interrupt_return_instr_i) begin
      sp_d = sp_q + `CCS_SP_BITS'(2);
    end else if (push_i) begin
      sp_d = sp_q - `CCS_SP_BITS'(1);
    end else if (pop_i) begin
      sp_d = sp_q + `CCS_SP_BITS'(1);
    end else begin
      sp_d = sp_q;
    end
  end

  assign sp_o = sp_full;
  assign io_rdata_o = !io_en_i ? 8'h00 :
                      (io_sel_i == CCS_IO_STATUS) ? status_o :
                      (io_sel_i == CCS_IO_SP_HIGH) ? sp_full[15:8] : sp_full[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // registers and entry sequence

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= `CCS_STATUS_RESET;
      sp_q <= `CCS_TOP_OF_DATA_MEMORY;
      hold_q <= 1'b0;
      rst_vec_q <= `CCS_VECTOR_ZERO;
    end else begin
      flags_q <= flags_d;
      sp_q <= sp_d;
      hold_q <= ien_rise || (hold_q && !instr_done_i);
      rst_vec_q <= boot_reset_vector_fuse_i ? `CCS_BOOT_START : `CCS_VECTOR_ZERO;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= CCS_ST_IDLE;
      cnt_q <= 3'h0;
      vec_valid_q <= 1'b0;
      vec_q <= `CCS_VECTOR_ZERO;
    end else begin
      vec_valid_q <= 1'b0;
      case (st_q)
        CCS_ST_IDLE: begin
          if (irq_take_o) begin
            st_q <= CCS_ST_ENTRY;
            cnt_q <= 3'h1;
            vec_q <= vec_calc;
          end
        end
        CCS_ST_ENTRY: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `CCS_ENTRY_CYCLES - 3'h1) begin
            st_q <= CCS_ST_IDLE;
            vec_valid_q <= 1'b1;
          end
        end
        default: st_q <= CCS_ST_IDLE;
      endcase
    end
  end

  assign irq_busy_o = st_q == CCS_ST_ENTRY;
  assign vector_valid_o = vec_valid_q;
  assign vector_addr_o = vec_q;
  assign reset_vector_o = rst_vec_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wire sp_other = sph_wr || spl_wr || irq_take_o || ret_i || interrupt_return_instr_i || pop_i;
  wire gpr_other = wr_en_i || ptr_upd || ds_wr;

  a_sign_xor: assert property (status_o[4] == (status_o[2] ^ status_o[3]))
    else $error("sign flag not n xor v");
  a_over_add: assert property (alu_flag_wr && !st_wr && alu_op_i == CCS_ALU_ADD &&
      !opa[7] && !opb[7] && sum9[7] |=> status_o[`CCS_FLAG_V])
    else $error("overflow missed on add");
  a_neg_flag: assert property (alu_flag_wr && !st_wr |=>
      status_o[`CCS_FLAG_N] == $past(alu_res[7]))
    else $error("negative flag wrong");
  a_zero_flag: assert property (alu_flag_wr && !st_wr |=>
      status_o[`CCS_FLAG_Z] == $past(alu_zero))
    else $error("zero flag wrong");
  a_alu_wback: assert property (alu_en_i && !gpr_other |=>
      gpr_q[$past(alu_dst_i)] == $past(alu_res))
    else $error("alu result not written back");
  a_push_step: assert property (push_i && !sp_other && !call_i |=>
      sp_o == $past(sp_o) - 16'h0001)
    else $error("push did not step by one");
  a_call_step: assert property (call_i && !sph_wr && !spl_wr && sp_o > 16'h0100 |=>
      sp_o == $past(sp_o) - 16'h0002)
    else $error("call did not step by two");
  a_take_gate: assert property (irq_take_o |-> status_o[`CCS_FLAG_I] &&
      |(irq_req_i & irq_en_i) && !suppress)
    else $error("interrupt taken while gated");
  a_external_request_zero_first: assert property (irq_take_o && irq_req_i[0] && irq_en_i[0] |->
      irq_ack_o[0])
    else $error("lowest vector not first");

  sequence s_entry_run;
    irq_busy_o [*3] ##1 (vector_valid_o && !irq_busy_o);
  endsequence
  a_entry_len: assert property (irq_take_o |=> s_entry_run)
    else $error("entry not four cycles");
  a_ien_clear: assert property (irq_take_o && !interrupt_return_instr_i && !sei_i |=>
      !status_o[`CCS_FLAG_I])
    else $error("global enable kept on entry");
  a_interrupt_return_instr_set: assert property (interrupt_return_instr_i |=> status_o[`CCS_FLAG_I] && hold_q)
    else $error("interrupt return left enable clear");
  a_sp_reset: assert property ($fell(rst_i) |-> sp_o == 16'h04FF)
    else $error("stack pointer reset wrong");

endmodule // ccs_core_state

// file: cpu_core_state_and_interrupt_entry_tb_top.sv
`include "ccs_defines.svh"

module cpu_core_state_and_interrupt_entry_tb_top import ccs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] rd_a_sel_i, rd_b_sel_i, wr_sel_i, alu_dst_i, alu_src_i;
  logic wr_en_i, wr_wide_i, alu_en_i, ds_en_i, ds_we_i, ptr_go_i, io_en_i, io_we_i;
  logic sei_i, cli_i, push_i, pop_i, call_i, ret_i, interrupt_return_instr_i, instr_done_i;
  logic vector_relocate_select_i, boot_reset_vector_fuse_i;
  logic app_lock_bit_two_i, boot_lock_bit_two_i;
  logic [15:0] wr_data_i, ds_addr_i;
  logic [7:0] ds_wdata_i, io_wdata_i;
  logic [5:0] ptr_disp_i;
  logic [`CCS_PC_BITS-1:0] pc_i, vector_addr_o, reset_vector_o;
  logic [`CCS_NUM_IRQ-1:0] irq_req_i, irq_en_i, irq_ack_o;
  ccs_alu_op_e alu_op_i;
  ccs_ptr_e ptr_sel_i;
  ccs_ptr_mode_e ptr_mode_i;
  ccs_io_e io_sel_i;
  logic [7:0] rd_a_data_o, rd_b_data_o, ds_rdata_o, io_rdata_o, status_o;
  logic [15:0] rd_word_o, ptr_addr_o, sp_o;
  logic ds_hit_o, irq_take_o, irq_busy_o, vector_valid_o;
  int err_count = 0;
  int compares = 0;

  always #4 clk_i = ~clk_i;

  ccs_core_state i_dut (
    .clk_i, .rst_i, .rd_a_sel_i, .rd_b_sel_i, .rd_a_data_o, .rd_b_data_o, .rd_word_o,
    .wr_en_i, .wr_wide_i, .wr_sel_i, .wr_data_i, .alu_en_i, .alu_op_i, .alu_dst_i,
    .alu_src_i, .ds_en_i, .ds_we_i, .ds_addr_i, .ds_wdata_i, .ds_hit_o, .ds_rdata_o,
    .ptr_go_i, .ptr_sel_i, .ptr_mode_i, .ptr_disp_i, .ptr_addr_o, .io_en_i, .io_we_i,
    .io_sel_i, .io_wdata_i, .io_rdata_o, .sei_i, .cli_i, .push_i, .pop_i, .call_i,
    .ret_i, .interrupt_return_instr_i, .instr_done_i, .irq_req_i, .irq_en_i, .vector_relocate_select_i,
    .boot_reset_vector_fuse_i, .app_lock_bit_two_i, .boot_lock_bit_two_i, .pc_i,
    .irq_take_o, .irq_ack_o, .irq_busy_o, .vector_valid_o, .vector_addr_o,
    .reset_vector_o, .status_o, .sp_o
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    compares++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic end_of_test;
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic io_acc(input ccs_io_e s, input logic we, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk_i);
    io_en_i <= 1'b1;
    io_we_i <= we;
    io_sel_i <= s;
    io_wdata_i <= d;
    #1 q = io_rdata_o;
    @(posedge clk_i);
    io_en_i <= 1'b0;
    io_we_i <= 1'b0;
    #1;
  endtask

  task automatic wrf(input logic wide, input logic [4:0] s, input logic [15:0] d);
    @(posedge clk_i);
    wr_en_i <= 1'b1;
    wr_wide_i <= wide;
    wr_sel_i <= s;
    wr_data_i <= d;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [4:0] a, input logic [4:0] b);
    @(posedge clk_i);
    rd_a_sel_i <= a;
    rd_b_sel_i <= b;
    #1;
  endtask

  task automatic alu(input ccs_alu_op_e op, input logic [4:0] d, input logic [4:0] s);
    @(posedge clk_i);
    alu_en_i <= 1'b1;
    alu_op_i <= op;
    alu_dst_i <= d;
    alu_src_i <= s;
    @(posedge clk_i);
    alu_en_i <= 1'b0;
    #1;
  endtask

  // k is {push, pop, call, ret, interrupt return}
  task automatic ev(input logic [4:0] k);
    @(posedge clk_i);
    {push_i, pop_i, call_i, ret_i, interrupt_return_instr_i} <= k;
    @(posedge clk_i);
    {push_i, pop_i, call_i, ret_i, interrupt_return_instr_i} <= 5'b0_0000;
    #1;
  endtask

  task automatic ptr(input ccs_ptr_e s, input ccs_ptr_mode_e m, input logic [5:0] d,
                     input logic [15:0] ea);
    @(posedge clk_i);
    ptr_go_i <= 1'b1;
    ptr_sel_i <= s;
    ptr_mode_i <= m;
    ptr_disp_i <= d;
    #1 chk(ptr_addr_o, ea);
    @(posedge clk_i);
    ptr_go_i <= 1'b0;
    #1;
  endtask

  // sei first, so the hold lets one instruction boundary pass before any take
  task automatic irq(input logic [24:0] rq, input logic [24:0] en, input logic rl,
                     input logic [1:0] lk, input logic [12:0] pc, input logic tk,
                     input logic [12:0] vec, input logic [24:0] ack);
    logic [15:0] s;
    @(posedge clk_i);
    sei_i <= 1'b1;
    irq_req_i <= rq;
    irq_en_i <= en;
    vector_relocate_select_i <= rl;
    {app_lock_bit_two_i, boot_lock_bit_two_i} <= lk;
    pc_i <= pc;
    @(posedge clk_i);
    sei_i <= 1'b0;
    instr_done_i <= 1'b1;
    #1 chk(irq_take_o, 1'b0);
    @(posedge clk_i);
    #1 s = sp_o;
    chk(irq_take_o, tk);
    if (tk) begin
      chk(irq_ack_o, ack);
      @(posedge clk_i);
      instr_done_i <= 1'b0;
      irq_req_i <= '0;
      #1 chk(irq_busy_o, 1'b1);
      chk(status_o[7], 1'b0);
      chk(sp_o, s - 16'h0002);
      repeat (2) @(posedge clk_i);
      #1 chk(vector_valid_o, 1'b0);
      @(posedge clk_i);
      #1 chk(vector_valid_o, 1'b1);
      chk(vector_addr_o, vec);
    end else begin
      @(posedge clk_i);
      instr_done_i <= 1'b0;
      irq_req_i <= '0;
      // nothing was taken, so drop the enable and let the next sei raise it again
      cli_i <= 1'b1;
      @(posedge clk_i);
      cli_i <= 1'b0;
      #1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] q;
    chk(sp_o, 16'h04FF);
    chk(status_o, 8'h00);
    io_acc(CCS_IO_SP_HIGH, 1'b0, 8'h00, q);
    chk(q, 8'h04);
    io_acc(CCS_IO_SP_LOW, 1'b0, 8'h00, q);
    chk(q, 8'hFF);
    io_acc(CCS_IO_SP_HIGH, 1'b1, 8'hFF, q);
    chk(sp_o, 16'h07FF);
    io_acc(CCS_IO_SP_HIGH, 1'b0, 8'h00, q);
    chk(q, 8'h07);
  endtask

  task automatic t_alu;
    wrf(1'b0, 5'd1, 16'h007F);
    wrf(1'b0, 5'd2, 16'h0001);
    wrf(1'b0, 5'd3, 16'h00FF);
    wrf(1'b0, 5'd4, 16'h0080);
    alu(CCS_ALU_ADD, 5'd1, 5'd2);
    rd(5'd1, 5'd2);
    chk(rd_a_data_o, 8'h80);
    chk(status_o[4:0], 5'b0_1100);
    alu(CCS_ALU_ADD, 5'd3, 5'd2);
    rd(5'd3, 5'd2);
    chk(rd_a_data_o, 8'h00);
    chk(status_o[4:0], 5'b0_0011);
    alu(CCS_ALU_SUB, 5'd4, 5'd2);
    rd(5'd4, 5'd2);
    chk(rd_a_data_o, 8'h7F);
    chk(status_o[4:0], 5'b1_1000);
    alu(CCS_ALU_AND, 5'd1, 5'd1);
    chk(status_o[4:0], 5'b1_0100);
    alu(CCS_ALU_SUB, 5'd5, 5'd2);
    chk(status_o[4:0], 5'b1_0101);
    alu(CCS_ALU_ADC, 5'd2, 5'd5);
    rd(5'd2, 5'd5);
    chk(rd_a_data_o, 8'h01);
    chk(status_o[4:0], 5'b0_0001);
  endtask

  task automatic t_regs;
    wrf(1'b1, 5'd26, 16'h1234);
    rd(5'd26, 5'd27);
    chk(rd_a_data_o, 8'h34);
    chk(rd_b_data_o, 8'h12);
    rd(5'd27, 5'd0);
    chk(rd_word_o, 16'h1234);
    @(posedge clk_i);
    ds_en_i <= 1'b1;
    ds_addr_i <= 16'h001A;
    #1 chk(ds_hit_o, 1'b1);
    chk(ds_rdata_o, 8'h34);
    @(posedge clk_i);
    ds_we_i <= 1'b1;
    ds_addr_i <= 16'h001F;
    ds_wdata_i <= 8'h5A;
    // 0x0020 aliases register 0 if the decode only looks at the low bits
    @(posedge clk_i);
    ds_addr_i <= 16'h0020;
    ds_wdata_i <= 8'hEE;
    #1 chk(ds_hit_o, 1'b0);
    @(posedge clk_i);
    ds_en_i <= 1'b0;
    ds_we_i <= 1'b0;
    rd(5'd31, 5'd0);
    chk(rd_a_data_o, 8'h5A);
    chk(rd_b_data_o, 8'h00);
    ptr(CCS_PTR_X, CCS_PM_POSTINC, 6'h00, 16'h1234);
    rd(5'd26, 5'd0);
    chk(rd_word_o, 16'h1235);
    ptr(CCS_PTR_X, CCS_PM_PREDEC, 6'h00, 16'h1234);
    rd(5'd26, 5'd0);
    chk(rd_word_o, 16'h1234);
    wrf(1'b1, 5'd28, 16'h0100);
    ptr(CCS_PTR_Y, CCS_PM_DISP, 6'h3F, 16'h013F);
    rd(5'd28, 5'd0);
    chk(rd_word_o, 16'h0100);
    ptr(CCS_PTR_Z, CCS_PM_PLAIN, 6'h00, 16'h5A00);
  endtask

  task automatic t_stack;
    logic [7:0] q;
    io_acc(CCS_IO_SP_HIGH, 1'b1, 8'h04, q);
    io_acc(CCS_IO_SP_LOW, 1'b1, 8'h80, q);
    chk(sp_o, 16'h0480);
    ev(5'b1_0000);
    chk(sp_o, 16'h047F);
    ev(5'b0_1000);
    chk(sp_o, 16'h0480);
    ev(5'b0_0100);
    chk(sp_o, 16'h047E);
    ev(5'b0_0010);
    chk(sp_o, 16'h0480);
  endtask

  task automatic t_irq;
    logic [15:0] s;
    @(posedge clk_i);
    irq_req_i <= 25'h000_0001;
    irq_en_i <= 25'h000_0001;
    instr_done_i <= 1'b1;
    #1 chk(irq_take_o, 1'b0);
    @(posedge clk_i);
    instr_done_i <= 1'b0;
    irq_req_i <= '0;
    irq(25'h00A, 25'h00A, 1'b0, 2'b00, 13'h0100, 1'b1, 13'h0004, 25'h002);
    irq(25'h00A, 25'h008, 1'b0, 2'b00, 13'h0100, 1'b1, 13'h0008, 25'h008);
    irq(25'h001, 25'h001, 1'b1, 2'b00, 13'h0100, 1'b1, 13'h1C02, 25'h001);
    irq(25'h001, 25'h001, 1'b1, 2'b10, 13'h0100, 1'b0, 13'h0000, 25'h000);
    irq(25'h001, 25'h001, 1'b0, 2'b01, 13'h1C10, 1'b0, 13'h0000, 25'h000);
    irq(25'h001, 25'h001, 1'b0, 2'b01, 13'h0100, 1'b1, 13'h0002, 25'h001);
    s = sp_o;
    ev(5'b0_0001);
    chk(status_o[7], 1'b1);
    chk(sp_o, s + 16'h0002);
    @(posedge clk_i);
    boot_reset_vector_fuse_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk(reset_vector_o, 13'h1C00);
    @(posedge clk_i);
    boot_reset_vector_fuse_i <= 1'b0;
    @(posedge clk_i);
    #1 chk(reset_vector_o, 13'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // the whole run is about 130 cycles, so this only fires on a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    end_of_test();
  end

  initial begin
    {rd_a_sel_i, rd_b_sel_i, wr_sel_i, alu_dst_i, alu_src_i, wr_en_i, wr_wide_i,
     alu_en_i, ds_en_i, ds_we_i, ptr_go_i, io_en_i, io_we_i, sei_i, cli_i, push_i,
     pop_i, call_i, ret_i, interrupt_return_instr_i, instr_done_i, vector_relocate_select_i,
     boot_reset_vector_fuse_i, app_lock_bit_two_i, boot_lock_bit_two_i, wr_data_i,
     ds_addr_i, ds_wdata_i, io_wdata_i, ptr_disp_i, pc_i, irq_req_i, irq_en_i} = '0;
    alu_op_i = CCS_ALU_ADD;
    ptr_sel_i = CCS_PTR_X;
    ptr_mode_i = CCS_PM_PLAIN;
    io_sel_i = CCS_IO_STATUS;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    t_reset();
    t_alu();
    t_regs();
    t_stack();
    t_irq();
    end_of_test();
  end

endmodule // cpu_core_state_and_interrupt_entry_tb_top
